// ===== rtl/dce_pkg.sv
// Purpose: Shared constants for the DMA channel engine
// Assumes: 16-bit registers in the low half of a 32-bit APB word
// Notes: Offsets are register indices; byte address is index times four
package dce_pkg;
  // ==========================================================
  // Register indices
  localparam logic [31:0] DCE_IDX_PROGRESS = 32'h5000_361e;
  localparam logic [31:0] DCE_IDX_SRC_LO = 32'h5000_3620;
  localparam logic [31:0] DCE_IDX_SRC_HI = 32'h5000_3622;
  localparam logic [31:0] DCE_IDX_DST_LO = 32'h5000_3624;
  localparam logic [31:0] DCE_IDX_DST_HI = 32'h5000_3626;
  localparam logic [31:0] DCE_IDX_THRESH = 32'h5000_3628;
  localparam logic [31:0] DCE_IDX_LENGTH = 32'h5000_362a;
  localparam logic [31:0] DCE_IDX_CONTROL = 32'h5000_362c;
  // Index bits compared against paddr[7:2]
  localparam int DCE_DEC_W = 6;
  // ==========================================================
  // Control field positions
  localparam int DCE_CTL_ON = 0;
  localparam int DCE_CTL_BW_LO = 1;
  localparam int DCE_CTL_IRQ_EN = 3;
  localparam int DCE_CTL_PERIPH = 4;
  localparam int DCE_CTL_DINC = 5;
  localparam int DCE_CTL_SINC = 6;
  localparam int DCE_CTL_CIRC = 7;
  localparam int DCE_CTL_PRIO_LO = 8;
  localparam int DCE_CTL_IDLE = 11;
  localparam int DCE_CTL_FILL = 12;
  localparam int DCE_CTL_EDGE = 13;
  localparam logic [15:0] DCE_CTL_WMASK = 16'h3fff;
  // ==========================================================
  // Reset values and codes
  localparam logic [15:0] DCE_RST_REG = 16'h0000;
  localparam logic [31:0] DCE_RST_WORD = 32'h0000_0000;
  localparam logic [1:0] DCE_BW_BYTE = 2'h0;
  localparam logic [1:0] DCE_BW_HALF = 2'h1;
  localparam logic [1:0] DCE_BW_WORD = 2'h2;
  typedef enum logic [2:0]
  {
    DCE_ST_IDLE = 3'b000,
    DCE_ST_WAIT = 3'b001,
    DCE_ST_READ = 3'b010,
    DCE_ST_WRITE = 3'b011,
    DCE_ST_GAP = 3'b100
  } dce_state_t;
endpackage

// ===== rtl/dce_addr_gen.sv
// Purpose: Item address from start address and progress index
// Assumes: Reserved width code steps like a single byte
// Notes: Combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module dce_addr_gen
(
  // Inputs
  input wire logic [31:0] base_i,
  input wire logic [15:0] index_i,
  input wire logic inc_i,
  input wire logic [1:0] width_i,
  // Result
  output logic [31:0] addr_o
);
  import dce_pkg::*;
  logic [31:0] step;
  // ==========================================================
  // Offset
  always_comb
  begin
    unique case (width_i)
      DCE_BW_HALF: step = {15'h0000, index_i, 1'b0};
      DCE_BW_WORD: step = {14'h0000, index_i, 2'b00};
      default: step = {16'h0000, index_i};
    endcase
    if (!inc_i)
    begin
      step = DCE_RST_WORD;
    end
    addr_o = base_i + step;
  end
endmodule
`default_nettype wire

// ===== rtl/dce_req_sense.sv
// Purpose: Synchronise and qualify the peripheral request pin
// Assumes: Request is asynchronous to clk_sys_i
// Notes: Level updates once the last two stages agree
`timescale 1ns/100ps
`default_nettype none
module dce_req_sense
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Request
  input wire logic req_i,
  output logic level_o,
  output logic rise_o
);
  import dce_pkg::*;
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  logic rise_reg;
  // ==========================================================
  // Synchroniser
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= req_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // ==========================================================
  // Qualified level and rising edge
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      lvl_reg <= 1'b0;
      rise_reg <= 1'b0;
    end
    else
    begin
      if (s2_reg == s3_reg)
      begin
        lvl_reg <= s3_reg;
      end
      rise_reg <= (s2_reg == s3_reg) && s3_reg && !lvl_reg;
    end
  end
  assign level_o = lvl_reg;
  assign rise_o = rise_reg;
endmodule
`default_nettype wire

// ===== rtl/dce_channel.sv
// Purpose: One DMA channel with APB registers and a bus master port
// Assumes: Bus target holds ack for one cycle per accepted request
// Notes: Channel arbitration and request muxing live outside
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module dce_channel
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // System bus master
  output logic bus_req_o,
  output logic bus_we_o,
  output logic [31:0] bus_addr_o,
  output logic [1:0] bus_size_o,
  output logic [31:0] bus_wdata_o,
  input wire logic [31:0] bus_rdata_i,
  input wire logic bus_ack_i,
  output logic bus_lock_o,
  // Peripheral request
  input wire logic dreq_i,
  // Status to system
  output logic irq_o,
  output logic busy_o,
  output logic [2:0] channel_prio_o
);
  import dce_pkg::*;
  // ==========================================================
  // Declarations
  dce_state_t state_reg;
  dce_state_t state_next;
  logic [15:0] src_lo_reg;
  logic [15:0] src_hi_reg;
  logic [15:0] dst_lo_reg;
  logic [15:0] dst_hi_reg;
  logic [15:0] thresh_reg;
  logic [15:0] length_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] index_reg;
  logic [15:0] index_next;
  logic [31:0] data_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic req_reg;
  logic we_reg;
  logic [31:0] addr_reg;
  logic lock_reg;
  logic irq_reg;
  logic pend_reg;
  logic req_level;
  logic req_rise;
  logic [31:0] src_addr;
  logic [31:0] dst_addr;
  logic [DCE_DEC_W-1:0] dec;
  logic hit;
  logic wr_en;
  logic item_done;
  logic last_item;
  logic restart;
  logic trigger;
  logic periph;
  logic fill;
  logic gap_en;
  logic [15:0] rd_mux;
  // ==========================================================
  // Control fields
  assign periph = ctrl_reg[DCE_CTL_PERIPH];
  assign fill = ctrl_reg[DCE_CTL_FILL];
  // Idle cycle only without request trigger
  assign gap_en = ctrl_reg[DCE_CTL_IDLE] && !periph;
  assign channel_prio_o = ctrl_reg[DCE_CTL_PRIO_LO +: 3];
  // ==========================================================
  // APB decode
  assign dec = paddr_i[DCE_DEC_W+1:2];
  assign wr_en = psel_i && penable_i && pwrite_i;
  always_comb
  begin
    hit = 1'b1;
    rd_mux = DCE_RST_REG;
    unique case (dec)
      DCE_IDX_PROGRESS[DCE_DEC_W-1:0]: rd_mux = index_reg;
      DCE_IDX_SRC_LO[DCE_DEC_W-1:0]: rd_mux = src_lo_reg;
      DCE_IDX_SRC_HI[DCE_DEC_W-1:0]: rd_mux = src_hi_reg;
      DCE_IDX_DST_LO[DCE_DEC_W-1:0]: rd_mux = dst_lo_reg;
      DCE_IDX_DST_HI[DCE_DEC_W-1:0]: rd_mux = dst_hi_reg;
      DCE_IDX_THRESH[DCE_DEC_W-1:0]: rd_mux = thresh_reg;
      DCE_IDX_LENGTH[DCE_DEC_W-1:0]: rd_mux = length_reg;
      DCE_IDX_CONTROL[DCE_DEC_W-1:0]: rd_mux = ctrl_reg;
      default: hit = 1'b0;
    endcase
  end
  // Read data sampled in setup so access phase needs no wait
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      prdata_reg <= DCE_RST_WORD;
      pslverr_reg <= 1'b0;
    end
    else if (psel_i && !penable_i)
    begin
      prdata_reg <= {16'h0000, rd_mux};
      pslverr_reg <= !hit;
    end
  end
  assign prdata_o = prdata_reg;
  assign pready_o = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i && pslverr_reg;
  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      src_lo_reg <= DCE_RST_REG;
      src_hi_reg <= DCE_RST_REG;
      dst_lo_reg <= DCE_RST_REG;
      dst_hi_reg <= DCE_RST_REG;
      thresh_reg <= DCE_RST_REG;
      length_reg <= DCE_RST_REG;
    end
    else if (wr_en)
    begin
      unique case (dec)
        DCE_IDX_SRC_LO[DCE_DEC_W-1:0]: src_lo_reg <= pwdata_i[15:0];
        DCE_IDX_SRC_HI[DCE_DEC_W-1:0]: src_hi_reg <= pwdata_i[15:0];
        DCE_IDX_DST_LO[DCE_DEC_W-1:0]: dst_lo_reg <= pwdata_i[15:0];
        DCE_IDX_DST_HI[DCE_DEC_W-1:0]: dst_hi_reg <= pwdata_i[15:0];
        DCE_IDX_THRESH[DCE_DEC_W-1:0]: thresh_reg <= pwdata_i[15:0];
        DCE_IDX_LENGTH[DCE_DEC_W-1:0]: length_reg <= pwdata_i[15:0];
        default:
        begin
        end
      endcase
    end
  end
  // ==========================================================
  // Control register
  // Circular only honoured with request trigger
  assign restart = ctrl_reg[DCE_CTL_CIRC] && periph;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= DCE_RST_REG;
    end
    else if (wr_en && dec == DCE_IDX_CONTROL[DCE_DEC_W-1:0])
    begin
      ctrl_reg <= pwdata_i[15:0] & DCE_CTL_WMASK;
    end
    else if (item_done && last_item && !restart)
    begin
      ctrl_reg[DCE_CTL_ON] <= 1'b0;
    end
  end
  // ==========================================================
  // Request sensing
  dce_req_sense u_req
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .req_i(dreq_i),
    .level_o(req_level),
    .rise_o(req_rise)
  );
  // Edge arriving on the consume cycle is kept
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      pend_reg <= 1'b0;
    end
    else if (req_rise)
    begin
      pend_reg <= 1'b1;
    end
    else if (state_reg == DCE_ST_WAIT && trigger)
    begin
      pend_reg <= 1'b0;
    end
  end
  assign trigger = ctrl_reg[DCE_CTL_EDGE] ? pend_reg : req_level;
  // ==========================================================
  // Sequencer
  // Last item when index reaches length
  assign last_item = index_reg == length_reg;
  assign item_done = state_reg == DCE_ST_WRITE && bus_ack_i;
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      DCE_ST_IDLE:
      begin
        if (ctrl_reg[DCE_CTL_ON])
        begin
          state_next = periph ? DCE_ST_WAIT : DCE_ST_READ;
        end
      end
      DCE_ST_WAIT:
      begin
        if (!ctrl_reg[DCE_CTL_ON])
        begin
          state_next = DCE_ST_IDLE;
        end
        else if (trigger)
        begin
          // Fill fetches only for item zero
          state_next = (fill && index_reg != DCE_RST_REG) ?
            DCE_ST_WRITE : DCE_ST_READ;
        end
      end
      DCE_ST_READ:
      begin
        if (bus_ack_i)
        begin
          state_next = DCE_ST_WRITE;
        end
      end
      DCE_ST_WRITE:
      begin
        if (bus_ack_i)
        begin
          if (last_item && !restart)
          begin
            state_next = DCE_ST_IDLE;
          end
          else if (periph)
          begin
            state_next = DCE_ST_WAIT;
          end
          else if (gap_en)
          begin
            state_next = DCE_ST_GAP;
          end
          else
          begin
            state_next = fill ? DCE_ST_WRITE : DCE_ST_READ;
          end
        end
      end
      DCE_ST_GAP:
      begin
        if (!ctrl_reg[DCE_CTL_ON])
        begin
          state_next = DCE_ST_IDLE;
        end
        else
        begin
          state_next = fill ? DCE_ST_WRITE : DCE_ST_READ;
        end
      end
      default: state_next = DCE_ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_reg <= DCE_ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end
  // ==========================================================
  // Progress index
  always_comb
  begin
    index_next = index_reg;
    if (item_done)
    begin
      index_next = last_item ? DCE_RST_REG : index_reg + 16'h0001;
    end
    else if (state_next == DCE_ST_IDLE)
    begin
      index_next = DCE_RST_REG;
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      index_reg <= DCE_RST_REG;
    end
    else
    begin
      index_reg <= index_next;
    end
  end
  // ==========================================================
  // Interrupt
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= item_done && ctrl_reg[DCE_CTL_IRQ_EN] &&
        thresh_reg == index_reg;
    end
  end
  assign irq_o = irq_reg;
  // ==========================================================
  // Address generation
  // Addresses from next index
  dce_addr_gen u_src
  (
    .base_i({src_hi_reg, src_lo_reg}),
    .index_i(index_next),
    .inc_i(ctrl_reg[DCE_CTL_SINC]),
    .width_i(ctrl_reg[DCE_CTL_BW_LO +: 2]),
    .addr_o(src_addr)
  );
  dce_addr_gen u_dst
  (
    .base_i({dst_hi_reg, dst_lo_reg}),
    .index_i(index_next),
    .inc_i(ctrl_reg[DCE_CTL_DINC]),
    .width_i(ctrl_reg[DCE_CTL_BW_LO +: 2]),
    .addr_o(dst_addr)
  );
  // ==========================================================
  // Bus request outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= DCE_RST_WORD;
      lock_reg <= 1'b0;
    end
    else
    begin
      req_reg <= state_next == DCE_ST_READ ||
        state_next == DCE_ST_WRITE;
      we_reg <= state_next == DCE_ST_WRITE;
      addr_reg <= (req_reg && !bus_ack_i) ? addr_reg :
        (state_next == DCE_ST_WRITE) ? dst_addr : src_addr;
      lock_reg <= state_next != DCE_ST_IDLE &&
        (fill || (!periph && !ctrl_reg[DCE_CTL_IDLE]));
    end
  end
  // Fetched item reused for every store in fill mode
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      data_reg <= DCE_RST_WORD;
    end
    else if (state_reg == DCE_ST_READ && bus_ack_i)
    begin
      data_reg <= bus_rdata_i;
    end
  end
  assign bus_req_o = req_reg;
  assign bus_we_o = we_reg;
  assign bus_addr_o = addr_reg;
  assign bus_size_o = ctrl_reg[DCE_CTL_BW_LO +: 2];
  assign bus_wdata_o = data_reg;
  assign bus_lock_o = lock_reg;
  assign busy_o = state_reg != DCE_ST_IDLE;
endmodule
`default_nettype wire

// ===== sim/dce_bus_model.sv
// Purpose: System bus target with a small word memory
// Assumes: One ack pulse per request after dly_i wait cycles
// Notes: Read data is inverted every cycle without a read ack, so no stale value
`timescale 1ns/100ps
`default_nettype none
module dce_bus_model
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Request from the channel, wait count from the bench
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] dly_i,
  // Answer
  output logic [31:0] rdata_o,
  output logic ack_o
);
  logic [31:0] mem [0:255];
  logic [3:0] cnt_reg;
  // ==========
  // Memory and answer
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 32'hc3c3_0000 | i;
  end
  always @(posedge clk_sys_i)
  begin
    ack_o <= 1'h0;
    rdata_o <= rst_i ? 32'h0000_0000 : ~rdata_o;
    if (rst_i || ack_o || !req_i)
      cnt_reg <= 4'h0;
    else if (cnt_reg >= dly_i)
    begin
      ack_o <= 1'h1;
      if (we_i)
        mem[addr_i[7:0]] <= wdata_i;
      else
        rdata_o <= mem[addr_i[7:0]];
    end
    else
      cnt_reg <= cnt_reg + 4'h1;
  end
endmodule
`default_nettype wire

// ===== sim/dce_channel_assertions.sv
// Purpose: Port-level checks of the DMA channel engine
// Assumes: Control is written only while no bus request is pending
// Notes: Bits 13:0 shadowed here; hardware only ever clears bit 0
`timescale 1ns/100ps
`default_nettype none
module dce_channel_assertions
(
  // Clock, reset and APB
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pslverr_o,
  // Bus master and status
  input wire logic bus_req_o,
  input wire logic bus_we_o,
  input wire logic [31:0] bus_addr_o,
  input wire logic [1:0] bus_size_o,
  input wire logic [31:0] bus_wdata_o,
  input wire logic [31:0] bus_rdata_i,
  input wire logic bus_ack_i,
  input wire logic bus_lock_o,
  input wire logic irq_o,
  input wire logic busy_o
);
  logic [13:0] sh_reg;
  logic wr_ctl;
  logic st_ack;
  assign wr_ctl = psel_i && penable_i && pwrite_i && paddr_i[7:2] == 6'h2c;
  assign st_ack = bus_req_o && bus_ack_i && bus_we_o;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      sh_reg <= 14'h0000;
    else if (wr_ctl)
      sh_reg <= pwdata_i[13:0];
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  a_err_unmapped:
    assert property (psel_i && penable_i |-> pslverr_o == !(paddr_i[7:2]
      inside {6'h1e, 6'h20, 6'h22, 6'h24, 6'h26, 6'h28, 6'h2a, 6'h2c}))
    else $error("error flag wrong for address");
  a_req_hold:
    assert property (bus_req_o && !bus_ack_i |=> bus_req_o
      && $stable(bus_addr_o) && $stable(bus_we_o))
    else $error("bus request changed before ack");
  a_store_data:
    assert property (bus_req_o && bus_ack_i && !bus_we_o |=> bus_req_o
      && bus_we_o && bus_wdata_o == $past(bus_rdata_i))
    else $error("store does not follow fetch");
  a_idle_gap:
    assert property (st_ack && sh_reg[11] && !sh_reg[4] && !sh_reg[12]
      |=> !bus_req_o)
    else $error("no idle cycle after store");
  a_lock_block:
    assert property (bus_req_o && !sh_reg[11] && !sh_reg[4] |-> bus_lock_o)
    else $error("blocking copy without lock");
  a_lock_fill:
    assert property (bus_req_o && sh_reg[12] |-> bus_lock_o)
    else $error("fill without lock");
  a_lock_trigger:
    assert property (bus_req_o && sh_reg[4] && !sh_reg[12] |-> !bus_lock_o)
    else $error("lock under peripheral trigger");
  a_size_field:
    assert property (bus_req_o |-> bus_size_o == sh_reg[2:1])
    else $error("bus size differs from width field");
  a_irq_enable:
    assert property (irq_o |-> sh_reg[3] && $past(st_ack))
    else $error("interrupt without enable or store");
  a_fill_once:
    assert property (st_ack && sh_reg[12] |=> !bus_req_o || bus_we_o)
    else $error("fill fetched again");
  a_start_now:
    assert property (wr_ctl && pwdata_i[0] && !pwdata_i[4] && !busy_o
      |-> ##[1:2] bus_req_o)
    else $error("channel did not start");
endmodule
bind dce_channel dce_channel_assertions u_chk (.clk_sys_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pslverr_o, .bus_req_o,
  .bus_we_o, .bus_addr_o, .bus_size_o, .bus_wdata_o, .bus_rdata_i,
  .bus_ack_i, .bus_lock_o, .irq_o, .busy_o);
`default_nettype wire

// ===== sim/dce_channel_test.sv
// Purpose: Self-checking bench of the DMA channel engine
// Assumes: Bus model on the master port, APB driven from here
// Notes: Rows cover memory moves; trigger, error and reset cases follow
`timescale 1ns/100ps
`default_nettype none
module dce_channel_test;
  import dce_pkg::*;
  typedef struct {logic [15:0] ctl, len, thr; logic [31:0] src, dst;
    logic [3:0] dly;} dce_row_t;
  logic clk_sys_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic dreq_i = 0, pready_o, pslverr_o, bus_req_o, bus_we_o, bus_ack_i;
  logic bus_lock_o, irq_o, busy_o, last_err;
  logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, bus_addr_o, rd, a, w;
  logic [31:0] bus_wdata_o, bus_rdata_i, st_a[$], st_d[$];
  logic [1:0] bus_size_o;
  logic [2:0] channel_prio_o;
  logic [3:0] dly = 0;
  int err_count = 0, samples_checked = 0, n_fetch = 0, n_irq = 0;
  dce_row_t rows[4], r;
  dce_channel i_dut (.clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .bus_req_o,
    .bus_we_o, .bus_addr_o, .bus_size_o, .bus_wdata_o, .bus_rdata_i,
    .bus_ack_i, .bus_lock_o, .dreq_i, .irq_o, .busy_o, .channel_prio_o);
  dce_bus_model i_mem (.clk_sys_i, .rst_i, .req_i(bus_req_o),
    .we_i(bus_we_o), .addr_i(bus_addr_o), .wdata_i(bus_wdata_o),
    .dly_i(dly), .rdata_o(bus_rdata_i), .ack_o(bus_ack_i));
  initial
    forever #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    if (!rst_i && bus_req_o && bus_ack_i && bus_we_o)
    begin
      st_a.push_back(bus_addr_o);
      st_d.push_back(bus_wdata_o);
    end
    if (!rst_i && bus_req_o && bus_ack_i && !bus_we_o)
      n_fetch++;
    if (irq_o === 1'h1)
      n_irq++;
  end
  // ==========
  // Tasks
  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang();
    err_count++;
    tally_and_finish();
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [5:0] ix,
    input logic [15:0] d);
    int n;
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= {24'h00_0000, ix, 2'h0};
    pwdata_i <= {16'h0000, d};
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready_o !== 1'h1 && n < 8);
    if (n >= 8)
      hang();
    rd = prdata_o;
    last_err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_sys_i);
  endtask
  task automatic wait_until(input bit idle, input int k);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while ((idle ? busy_o !== 1'h0 : st_a.size() < k) && n < 300)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 300)
      hang();
    repeat (2) @(posedge clk_sys_i);
  endtask
  // ==========
  // Sequence
  initial
  begin
    rows[0] = '{16'h006c, 16'h0002, 16'h0001, 32'h0001_0010, 32'h0002_0080,
      4'h0};
    rows[1] = '{16'h082a, 16'h0001, 16'h0005, 32'h0000_0020, 32'h0000_0090,
      4'h3};
    rows[2] = '{16'h1020, 16'h0003, 16'h0000, 32'h0000_0030, 32'h0000_00a0,
      4'h1};
    rows[3] = '{16'h0068, 16'h0000, 16'h0000, 32'h0000_00ff, 32'h0000_0040,
      4'h2};
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    foreach (rows[i])
    begin
      r = rows[i];
      dly <= r.dly;
      st_a.delete();
      st_d.delete();
      n_fetch = 0;
      n_irq = 0;
      apb(1, DCE_IDX_SRC_LO[5:0], r.src[15:0]);
      apb(1, DCE_IDX_SRC_HI[5:0], r.src[31:16]);
      apb(1, DCE_IDX_DST_LO[5:0], r.dst[15:0]);
      apb(1, DCE_IDX_DST_HI[5:0], r.dst[31:16]);
      apb(1, DCE_IDX_THRESH[5:0], r.thr);
      apb(1, DCE_IDX_LENGTH[5:0], r.len);
      apb(1, DCE_IDX_CONTROL[5:0], r.ctl | 16'h0001);
      wait_until(1, 0);
      w = 32'h1 << r.ctl[2:1];
      chk("stores", r.len + 1, st_a.size());
      chk("fetches", r.ctl[12] ? 1 : r.len + 1, n_fetch);
      chk("irqs", (r.ctl[3] && r.thr <= r.len) ? 1 : 0, n_irq);
      for (int k = 0; k < st_a.size(); k++)
      begin
        a = r.src + ((r.ctl[12] || !r.ctl[6]) ? 0 : k * w);
        chk("store addr", r.dst + (r.ctl[5] ? k * w : 0), st_a[k]);
        chk("store data", 32'hc3c3_0000 | a[7:0], st_d[k]);
      end
      apb(0, DCE_IDX_PROGRESS[5:0], 16'h0000);
      chk("index", 0, rd);
      apb(0, DCE_IDX_CONTROL[5:0], 16'h0000);
      chk("control", {16'h0000, r.ctl}, rd);
      apb(0, DCE_IDX_SRC_HI[5:0], 16'h0000);
      chk("src hi", {16'h0000, r.src[31:16]}, rd);
      apb(0, DCE_IDX_DST_LO[5:0], 16'h0000);
      chk("dst lo", {16'h0000, r.dst[15:0]}, rd);
    end
    st_a.delete();
    st_d.delete();
    n_fetch = 0;
    apb(1, DCE_IDX_SRC_LO[5:0], 16'h0050);
    apb(1, DCE_IDX_DST_LO[5:0], 16'h0060);
    apb(1, DCE_IDX_LENGTH[5:0], 16'h0001);
    apb(1, DCE_IDX_CONTROL[5:0], 16'h0875);
    repeat (10) @(posedge clk_sys_i);
    chk("no trigger", 0, n_fetch);
    dreq_i <= 1'h1;
    wait_until(0, 2);
    dreq_i <= 1'h0;
    wait_until(1, 0);
    chk("level items", 2, st_a.size());
    chk("level data", 32'hc3c3_0054, st_d[1]);
    st_a.delete();
    apb(1, DCE_IDX_CONTROL[5:0], 16'h2075);
    dreq_i <= 1'h1;
    repeat (30) @(posedge clk_sys_i);
    chk("edge items", 1, st_a.size());
    apb(1, DCE_IDX_PROGRESS[5:0], 16'h1234);
    apb(0, DCE_IDX_PROGRESS[5:0], 16'h0000);
    chk("index mid", 1, rd);
    dreq_i <= 1'h0;
    repeat (6) @(posedge clk_sys_i);
    dreq_i <= 1'h1;
    wait_until(0, 2);
    wait_until(1, 0);
    dreq_i <= 1'h0;
    st_a.delete();
    st_d.delete();
    apb(1, DCE_IDX_LENGTH[5:0], 16'h0000);
    apb(1, DCE_IDX_CONTROL[5:0], 16'h00f5);
    dreq_i <= 1'h1;
    wait_until(0, 3);
    dreq_i <= 1'h0;
    repeat (20) @(posedge clk_sys_i);
    apb(0, DCE_IDX_CONTROL[5:0], 16'h0000);
    chk("circular on", 32'h0000_00f5, rd);
    chk("circular data", 32'hc3c3_0050, st_d[2]);
    chk("circular addr", 32'h0000_0060, st_a[2]);
    apb(1, DCE_IDX_CONTROL[5:0], 16'h0000);
    wait_until(1, 0);
    apb(1, DCE_IDX_CONTROL[5:0], 16'hc700);
    apb(0, DCE_IDX_CONTROL[5:0], 16'h0000);
    chk("upper bits", 32'h0000_0700, rd);
    chk("prio", 7, channel_prio_o);
    apb(0, 6'h00, 16'h0000);
    chk("unmapped err", 1, last_err);
    chk("unmapped data", 0, rd);
    rst_i <= 1'h1;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 8; i++)
    begin
      apb(0, DCE_IDX_PROGRESS[5:0] + 6'(2 * i), 16'h0000);
      chk("reset value", 0, rd);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
